/* File: common/adc_cfg_map.svh */
`ifndef ADC_CFG_MAP_SVH
`define ADC_CFG_MAP_SVH
// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define GAIN_IDX 8'h03
`define RATE_IDX 8'h04
`define STAT_IDX 8'h08
`define CTRL_IDX 8'h09
`define COUNT_IDX 8'h0A
// ****************************************************************
// reset values and field positions
// ****************************************************************
`define GAIN_RST 8'h00
`define RATE_RST 8'h14
`define DLY_MSB 7
`define DLY_LSB 5
`define AMP_MSB 4
`define AMP_LSB 3
`define GAIN_MSB 2
`define GAIN_LSB 0
`define CHOP_BIT 7
`define CLK_BIT 6
`define MODE_BIT 5
`define FILT_BIT 4
`define RATE_MSB 3
`define RATE_LSB 0
`define CTRL_START_BIT 0
`define RATE_RSV 4'hF
// ****************************************************************
// first-conversion delay in modulator periods
// ****************************************************************
`define DLY_0 13'h000E
`define DLY_1 13'h0019
`define DLY_2 13'h0040
`define DLY_3 13'h0100
`define DLY_4 13'h0400
`define DLY_5 13'h0800
`define DLY_6 13'h1000
`define DLY_7 13'h1000
`endif

/* File: common/adc_cfg_pkg.sv */
`default_nettype none
package adc_cfg_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_DELAY,
    SEQ_CONV
  } seq_state_e;
  typedef enum logic [1:0] {
    AMP_BYPASS,
    AMP_ON,
    AMP_RSV2,
    AMP_RSV3
  } amp_mode_e;
  typedef logic [12:0] dly_t;
endpackage
`default_nettype wire

/* File: common/conv_if.sv */
`default_nettype none
interface conv_if #(parameter int DATA_W = 16);
  logic filter_reset;
  logic conv_start;
  logic conv_done;
  logic [DATA_W-1:0] conv_data;
  logic chop_en;
  logic chop_phase;
  modport seq (output filter_reset, output conv_start,
    input conv_done, input chop_en, input chop_phase);
  modport avg (input filter_reset, input conv_done, input conv_data,
    input chop_en, output chop_phase);
endinterface
`default_nettype wire

/* File: design/conv_sequencer.sv */
`include "adc_cfg_map.svh"
`default_nettype none
module conv_sequencer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic restart,
  input wire logic single_mode,
  input wire logic [2:0] delay_code,
  input wire logic mod_tick,
  output logic delaying,
  output logic converting,
  conv_if.seq cv
);
  adc_cfg_pkg::seq_state_e state;
  adc_cfg_pkg::seq_state_e next_state;
  adc_cfg_pkg::dly_t count;
  adc_cfg_pkg::dly_t dly_load;
  logic start_now;
  logic again;

  // ****************************************************************
  // delay lookup
  // ****************************************************************
  always_comb begin
    case (delay_code)
      3'h0: dly_load = `DLY_0;
      3'h1: dly_load = `DLY_1;
      3'h2: dly_load = `DLY_2;
      3'h3: dly_load = `DLY_3;
      3'h4: dly_load = `DLY_4;
      3'h5: dly_load = `DLY_5;
      3'h6: dly_load = `DLY_6;
      default: dly_load = `DLY_7;
    endcase
  end

  // single-shot with chop still needs the second, swapped reading
  assign again = !single_mode || (cv.chop_en && !cv.chop_phase);
  assign start_now = (state == adc_cfg_pkg::SEQ_DELAY) && mod_tick &&
    (count == 13'h0001);

  always_comb begin
    next_state = state;
    case (state)
      adc_cfg_pkg::SEQ_IDLE: next_state = state;
      adc_cfg_pkg::SEQ_DELAY: begin
        if (start_now) begin
          next_state = adc_cfg_pkg::SEQ_CONV;
        end
      end
      adc_cfg_pkg::SEQ_CONV: begin
        if (cv.conv_done && !again) begin
          next_state = adc_cfg_pkg::SEQ_IDLE;
        end
      end
      default: next_state = adc_cfg_pkg::SEQ_IDLE;
    endcase
    if (restart) begin
      next_state = adc_cfg_pkg::SEQ_DELAY;
    end
  end

  // ****************************************************************
  // state and counters
  // ****************************************************************
  // out of reset the first conversion waits the default delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= adc_cfg_pkg::SEQ_DELAY;
      count <= `DLY_0;
      cv.filter_reset <= 1'b0;
      cv.conv_start <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      cv.filter_reset <= restart;
      // a restart cancels any start that was about to go out
      cv.conv_start <= !restart && (start_now ||
        ((state == adc_cfg_pkg::SEQ_CONV) && cv.conv_done &&
        again));
      if (restart) begin
        count <= dly_load;
      end else if (start_now) begin
        count <= 13'h0000;
      end else if (mod_tick && (state == adc_cfg_pkg::SEQ_DELAY)) begin
        count <= count - 13'h0001;
      end
    end
  end

  assign delaying = (state == adc_cfg_pkg::SEQ_DELAY);
  assign converting = (state == adc_cfg_pkg::SEQ_CONV);
endmodule // conv_sequencer
`default_nettype wire

/* File: design/chop_average.sv */
`default_nettype none
module chop_average #(parameter int DATA_W = 16) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  output logic [DATA_W-1:0] result_data,
  output logic result_valid,
  conv_if.avg cv
);
  logic [DATA_W-1:0] first;
  logic [DATA_W:0] sum;

  // sign-extended sum so the average cannot overflow
  assign sum = {first[DATA_W-1], first} +
    {cv.conv_data[DATA_W-1], cv.conv_data};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first <= '0;
      cv.chop_phase <= 1'b0;
      result_data <= '0;
      result_valid <= 1'b0;
    end else if (ce) begin
      result_valid <= 1'b0;
      if (cv.filter_reset) begin
        cv.chop_phase <= 1'b0;
      end else if (cv.conv_done) begin
        if (!cv.chop_en) begin
          result_data <= cv.conv_data;
          result_valid <= 1'b1;
          cv.chop_phase <= 1'b0;
        end else if (!cv.chop_phase) begin
          first <= cv.conv_data;
          cv.chop_phase <= 1'b1;
        end else begin
          result_data <= sum[DATA_W:1];
          result_valid <= 1'b1;
          cv.chop_phase <= 1'b0;
        end
      end
    end
  end
endmodule // chop_average
`default_nettype wire

/* File: design/adc_gain_rate_config.sv */
// Behaviour
// - config write resets filter, delays first conversion
// - delay codes 14, 25, 64, 256 and longer
// - amp field: 00 bypass, 01 enabled, rest reserved
// - gain equals two to the gain code when amp enabled, unity in bypass
// - chop swaps inputs, averages two readings
// - clock bit picks internal or external clock
// - mode bit: continuous or single-shot conversions
// - filter bit: sinc3 or low-latency filter
// - rate field selects output data rate
// - rate register resets to 14h
`include "adc_cfg_map.svh"
`default_nettype none
module adc_gain_rate_config #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic mod_tick_int,
  input wire logic mod_tick_ext,
  input wire logic conv_done,
  input wire logic [DATA_W-1:0] conv_data,
  output logic filter_reset,
  output logic conv_start,
  output logic input_swap,
  output logic amp_enable,
  output logic [7:0] amp_gain,
  output logic ext_clk_sel,
  output logic single_shot,
  output logic low_latency_filter,
  output logic [3:0] output_rate_field,
  output logic [DATA_W-1:0] result_data,
  output logic result_valid
);
  // ****************************************************************
  // bus address phase
  // ****************************************************************
  logic dp_wr;
  logic dp_rd;
  logic [7:0] dp_idx;
  logic [7:0] gain_config;
  logic [7:0] data_rate_config;
  logic start_cmd;
  logic [15:0] result_count;
  logic delaying;
  logic converting;
  logic [31:0] status_word;
  logic [31:0] next_rdata;

  wire logic addr_take = hsel && htrans[1] && hready && ce;
  wire logic [7:0] addr_idx = 8'(haddr[ADDR_W-1:2]);
  // word alignment is assumed; hsize is not decoded as only words occur
  wire logic unused_size = |hsize;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      dp_idx <= 8'h00;
    end else if (ce) begin
      dp_wr <= addr_take && hwrite;
      dp_rd <= addr_take && !hwrite;
      dp_idx <= addr_idx;
    end
  end

  // ****************************************************************
  // data phase decode
  // ****************************************************************
  wire logic sel_gain = dp_idx == `GAIN_IDX;
  wire logic sel_rate = dp_idx == `RATE_IDX;
  wire logic sel_stat = dp_idx == `STAT_IDX;
  wire logic sel_ctrl = dp_idx == `CTRL_IDX;
  wire logic sel_count = dp_idx == `COUNT_IDX;
  wire logic wr_gain = dp_wr && sel_gain;
  wire logic wr_rate = dp_wr && sel_rate;
  wire logic wr_start = dp_wr && sel_ctrl && hwdata[`CTRL_START_BIT];
  // any write to either config register counts as a change; comparing
  // old and new would save a restart but hides software intent
  wire logic restart = wr_gain || wr_rate || start_cmd;

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_config <= `GAIN_RST;
      data_rate_config <= `RATE_RST;
      start_cmd <= 1'b0;
    end else if (ce) begin
      start_cmd <= wr_start;
      if (wr_gain) begin
        gain_config <= hwdata[7:0];
      end
      if (wr_rate) begin
        data_rate_config <= hwdata[7:0];
      end
    end
  end

  // ****************************************************************
  // field decode
  // ****************************************************************
  wire logic [2:0] delay_code = gain_config[`DLY_MSB:`DLY_LSB];
  // a gain write restarts with the delay it carries, not the old one
  wire logic [2:0] seq_delay_code = wr_gain ?
    hwdata[`DLY_MSB:`DLY_LSB] : delay_code;
  wire logic [2:0] gain_code = gain_config[`GAIN_MSB:`GAIN_LSB];
  wire adc_cfg_pkg::amp_mode_e amp_mode =
    adc_cfg_pkg::amp_mode_e'(gain_config[`AMP_MSB:`AMP_LSB]);
  wire logic chop_on = data_rate_config[`CHOP_BIT];
  wire logic amp_rsv = (amp_mode == adc_cfg_pkg::AMP_RSV2) ||
    (amp_mode == adc_cfg_pkg::AMP_RSV3);
  wire logic rate_rsv =
    data_rate_config[`RATE_MSB:`RATE_LSB] == `RATE_RSV;
  // bypass with a gain other than unity is a software fault
  wire logic gain_fault = (amp_mode == adc_cfg_pkg::AMP_BYPASS) &&
    (gain_code != 3'h0);
  wire logic mod_tick = ext_clk_sel ? mod_tick_ext : mod_tick_int;

  assign amp_enable = amp_mode == adc_cfg_pkg::AMP_ON;
  // bypassed amplifier passes the signal at unity gain
  assign amp_gain = amp_enable ? (8'h01 << gain_code) : 8'h01;
  assign ext_clk_sel = data_rate_config[`CLK_BIT];
  assign single_shot = data_rate_config[`MODE_BIT];
  assign low_latency_filter = data_rate_config[`FILT_BIT];
  assign output_rate_field =
    data_rate_config[`RATE_MSB:`RATE_LSB];

  // ****************************************************************
  // conversion sequencing and chop averaging
  // ****************************************************************
  conv_if #(.DATA_W(DATA_W)) cv ();

  assign cv.conv_done = conv_done;
  assign cv.conv_data = conv_data;
  assign cv.chop_en = chop_on;
  assign filter_reset = cv.filter_reset;
  assign conv_start = cv.conv_start;
  assign input_swap = cv.chop_phase;

  conv_sequencer u_seq (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .restart(restart),
    .single_mode(single_shot),
    .delay_code(seq_delay_code),
    .mod_tick(mod_tick),
    .delaying(delaying),
    .converting(converting),
    .cv(cv.seq)
  );

  chop_average #(.DATA_W(DATA_W)) u_avg (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .result_data(result_data),
    .result_valid(result_valid),
    .cv(cv.avg)
  );

  // ****************************************************************
  // result counter
  // ****************************************************************
  // cleared by the filter reset so software can tell stale results
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_count <= 16'h0000;
    end else if (ce) begin
      if (cv.filter_reset) begin
        result_count <= 16'h0000;
      end else if (result_valid) begin
        result_count <= result_count + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  assign status_word = {16'(result_data), 10'h000, gain_fault,
    rate_rsv, amp_rsv, cv.chop_phase, converting, delaying};

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (sel_gain) begin
      next_rdata = {24'h000000, gain_config};
    end else if (sel_rate) begin
      next_rdata = {24'h000000, data_rate_config};
    end else if (sel_stat) begin
      next_rdata = status_word;
    end else if (sel_count) begin
      next_rdata = {16'h0000, result_count};
    end else begin
      next_rdata = 32'h0000_0000;
    end
  end

  // read data only shown in a read data phase; writes read back at once
  assign hrdata = dp_rd ? next_rdata : 32'h0000_0000;
  assign hreadyout = ce || unused_size && 1'b0;
  assign hresp = 1'b0;
endmodule // adc_gain_rate_config
`default_nettype wire

/* File: test/adc_gain_rate_config_monitor.sv */
`include "adc_cfg_map.svh"
`default_nettype none
module adc_gain_rate_config_monitor #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic mod_tick_int,
  input wire logic mod_tick_ext,
  input wire logic conv_done,
  input wire logic filter_reset,
  input wire logic conv_start,
  input wire logic input_swap,
  input wire logic amp_enable,
  input wire logic [7:0] amp_gain,
  input wire logic ext_clk_sel,
  input wire logic single_shot,
  input wire logic result_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ticks;
  logic pend;
  wire logic [ADDR_W-3:0] idx = haddr[ADDR_W-1:2];
  wire logic cfg_wr = hsel && htrans[1] && hready && ce && hwrite &&
    (idx == (ADDR_W-2)'(`GAIN_IDX) || idx == (ADDR_W-2)'(`RATE_IDX));
  wire logic tick = ext_clk_sel ? mod_tick_ext : mod_tick_int;
  // saturating count of selected ticks since the last restart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ticks <= 4'h0;
      pend <= 1'b1;
    end else if (filter_reset) begin
      // the sequencer already counts a tick at this edge
      ticks <= {3'h0, tick};
      pend <= 1'b1;
    end else begin
      if (tick && ticks != 4'hF) ticks <= ticks + 4'h1;
      if (conv_start) pend <= 1'b0;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_bypass_unity: assert property (
    !amp_enable |-> amp_gain == 8'h01) else $error("gain not unity");
  chk_gain_pow2: assert property (
    $onehot(amp_gain)) else $error("gain not a power of two");
  chk_write_restart: assert property (
    cfg_wr |-> ##2 filter_reset) else $error("no filter reset");
  chk_delay_floor: assert property (
    filter_reset |=> !conv_start [*8]) else $error("start too early");
  chk_delay_ticks: assert property (
    conv_start && pend |-> ticks >= 4'hE) else $error("delay too short");
  chk_chop_swap: assert property (
    $rose(input_swap) |-> $past(conv_done)) else $error("swap uncaused");
  chk_chop_pair: assert property (
    conv_done && input_swap |=> result_valid && !input_swap)
    else $error("chop pair not closed");
  chk_cont_next: assert property (
    conv_done && !single_shot && !input_swap |=> conv_start)
    else $error("continuous start missing");
  chk_single_stop: assert property (
    conv_done && single_shot && input_swap |=> !conv_start [*8])
    else $error("single shot restarted");
endmodule // adc_gain_rate_config_monitor
bind adc_gain_rate_config adc_gain_rate_config_monitor #(
  .DATA_W(DATA_W), .ADDR_W(ADDR_W)) mon (.hclk, .hresetn, .ce, .hsel,
  .haddr, .htrans, .hwrite, .hready, .mod_tick_int, .mod_tick_ext,
  .conv_done, .filter_reset, .conv_start, .input_swap, .amp_enable,
  .amp_gain, .ext_clk_sel, .single_shot, .result_valid);
`default_nettype wire

/* File: test/adc_gain_rate_config_tb_top.sv */
`default_nettype none
module adc_gain_rate_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  logic mod_tick_int, mod_tick_ext, conv_done, filter_reset, conv_start;
  logic input_swap, amp_enable, ext_clk_sel, single_shot, result_valid;
  logic low_latency_filter;
  logic [15:0] conv_data, result_data;
  logic [7:0] amp_gain;
  logic [3:0] output_rate_field;
  int miscompares = 0;
  int checked = 0;
  logic [31:0] rq;
  int dly[8] = '{14, 25, 64, 256, 1024, 2048, 4096, 4096};
  wire logic [7:0] rate_outs = {1'b0, ext_clk_sel, single_shot,
    low_latency_filter, output_rate_field};
  assign hready = hreadyout;
  adc_gain_rate_config uut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .mod_tick_int, .mod_tick_ext, .conv_done, .conv_data, .filter_reset,
    .conv_start, .input_swap, .amp_enable, .amp_gain, .ext_clk_sel,
    .single_shot, .low_latency_filter, .output_rate_field, .result_data,
    .result_valid);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ****************************************************************
  // bus and conversion tasks
  // ****************************************************************
  task automatic cmp(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx,
      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {2'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, {24'h0, d}, q);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e,
      input string nm);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0, q);
    cmp(nm, {24'h0, e}, q);
  endtask
  // the unselected tick line stays high so a wrong source miscounts
  task automatic delay_run(input logic ext, input int n);
    int k;
    k = 0;
    #1 cmp("filter_reset", 32'h1, filter_reset);
    repeat (9000) begin
      @(posedge hclk);
      if (ext ? mod_tick_ext : mod_tick_int) k++;
      mod_tick_int <= ext ? 1'b1 : ~mod_tick_int;
      mod_tick_ext <= ext ? ~mod_tick_ext : 1'b1;
      #1 if (conv_start === 1'b1) break;
    end
    @(posedge hclk);
    mod_tick_int <= 1'b0;
    mod_tick_ext <= 1'b0;
    cmp("tick count", n, k);
  endtask
  task automatic done(input logic [15:0] d);
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge hclk);
    conv_done <= 1'b0;
    #1;
  endtask
  task automatic wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge hclk);
    miscompares++;
    wrap_up();
  end
  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mod_tick_int = 1'b0;
    mod_tick_ext = 1'b0;
    conv_done = 1'b0;
    conv_data = 16'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ce <= 1'b0;
    repeat (2) @(posedge hclk);
    cmp("ready held", 32'h0, hreadyout);
    ce <= 1'b1;
    rd(8'h03, 8'h00, "gain reset");
    rd(8'h04, 8'h14, "rate reset");
    cmp("rate outs", 32'h14, rate_outs);
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00, "unmapped");
    for (int g = 0; g < 8; g++) begin
      wr(8'h03, {5'h01, g[2:0]});
      rd(8'h03, {5'h01, g[2:0]}, "gain rb");
      cmp("amp gain", 32'h1 << g, amp_gain);
    end
    for (int a = 0; a < 4; a++) begin
      wr(8'h03, {3'h0, a[1:0], 3'h0});
      rd(8'h03, {3'h0, a[1:0], 3'h0}, "amp rb");
      cmp("amp on", a == 1, amp_enable);
    end
    for (int r = 0; r < 16; r++) begin
      wr(8'h04, {r[3:0], r[3:0]});
      rd(8'h04, {r[3:0], r[3:0]}, "rate rb");
      cmp("rate outs", {r[2:0], r[3:0]}, rate_outs);
    end
    wr(8'h04, 8'h14);
    for (int c = 0; c < 8; c++) begin
      wr(8'h03, {c[2:0], 5'h00});
      delay_run(1'b0, dly[c]);
    end
    wr(8'h03, 8'h00);
    wr(8'h04, 8'h54);
    delay_run(1'b1, 14);
    done(16'h1234);
    cmp("result ok", 32'h1, result_valid);
    cmp("result", 32'h1234, result_data);
    @(posedge hclk);
    wr(8'h04, 8'hB4);
    delay_run(1'b0, 14);
    done(16'h0064);
    cmp("swap", 32'h1, input_swap);
    repeat (3) @(posedge hclk);
    done(16'hFFEC);
    cmp("chop ok", 32'h1, result_valid);
    cmp("chop avg", 32'h0028, result_data);
    repeat (10) @(posedge hclk);
    rd(8'h0A, 8'h01, "result count");
    bus(1'b0, 8'h08, 32'h0, rq);
    cmp("status idle", 32'h0028_0000, rq);
    wr(8'h09, 8'h01);
    bus(1'b0, 8'h08, 32'h0, rq);
    cmp("status delay", 32'h0028_0001, rq);
    wrap_up();
  end
endmodule // adc_gain_rate_config_tb_top
`default_nettype wire
